// ===== shared/lg_pkg.sv
// constants for the light grid configuration and status block
package lg_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_PER_S = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_PER_S;
    localparam int unsigned TEST_HOLD_MS = 500;
    localparam int unsigned MUTE_LIMIT_MIN = 10;
    localparam int unsigned MUTE_LIMIT_MS = MUTE_LIMIT_MIN * 60 * 1000;
    localparam int unsigned BOOT_CYCLES = 3;
    localparam int unsigned TMR_W = 20;
    // switch positions, switch n sits at bit n-1
    localparam int unsigned SW_UNLIM_A = 0;
    localparam int unsigned SW_UNLIM_B = 4;
    localparam int unsigned SW_MUTE_A = 1;
    localparam int unsigned SW_MUTE_B = 5;
    localparam int unsigned SW_FB_A = 2;
    localparam int unsigned SW_FB_B = 6;
    localparam int unsigned SW_ILOCK_A = 3;
    localparam int unsigned SW_ILOCK_B = 7;
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // status fields
    localparam int unsigned ST_OUTS_ON = 0;
    localparam int unsigned ST_ALIGN = 1;
    localparam int unsigned ST_MUTE = 2;
    localparam int unsigned ST_CFG_OK = 3;
    localparam int unsigned ST_MFAULT = 4;
    localparam int unsigned ST_TRIP = 5;
    localparam int unsigned ST_DIP = 8;
    // control fields
    localparam int unsigned CTRL_FORCE_SAFE = 0;
    // event bits
    localparam int unsigned EV_BREAK = 0;
    localparam int unsigned EV_TEST = 1;
    localparam int unsigned EV_MTO = 2;
    localparam int unsigned EV_FB = 3;
    localparam int unsigned EV_N = 4;
    typedef enum logic [1:0] {
        S_BOOT,
        S_ALIGN_HOLD,
        S_ALIGN,
        S_RUN
    } mode_e;
endpackage

// ===== shared/tmr_if.sv
// carrier between the control logic and a tick-counting hold timer
`timescale 1ns/1ps
`default_nettype none
interface tmr_if #(parameter int unsigned W = 20);
    logic run;
    logic tick;
    logic [W-1:0] limit;
    logic done;
    modport owner (output run, output tick, output limit, input done);
    modport timer (input run, input tick, input limit, output done);
endinterface
`default_nettype wire

// ===== design/hold_timer.sv
// counts ticks while run is high and holds done once the limit is reached
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
    parameter int unsigned W = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    tmr_if.timer t
);
    logic [W-1:0] cnt_q;
    logic done_q;

    // dropping run restarts the count, so only an unbroken interval counts
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else if (!t.run) begin
            cnt_q <= '0;
        end else if (t.tick && cnt_q != t.limit) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= t.run && (cnt_q == t.limit);
        end
    end

    assign t.done = done_q;
endmodule
`default_nettype wire

// ===== design/light_grid_config_and_status.sv
// configuration decode, alignment mode, indicators and safety outputs of the receiver
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module light_grid_config_and_status #(
    parameter int unsigned TICK_CYCLES = lg_pkg::TICK_CYCLES,
    parameter int unsigned TEST_HOLD_TICKS = lg_pkg::TEST_HOLD_MS,
    parameter int unsigned MUTE_LIMIT_TICKS = lg_pkg::MUTE_LIMIT_MS
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] dip_on_i,
    input wire logic button_pressed_i,
    input wire logic upper_beam_ok_i,
    input wire logic lower_beam_ok_i,
    input wire logic field_clear_i,
    input wire logic muting_sensor_i,
    input wire logic muting_lamp_ok_i,
    input wire logic muting_wiring_ok_i,
    input wire logic feedback_closed_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [1:0] safety_output_pair_o,
    output logic led_green_o,
    output logic led_red_o,
    output logic led_upper_o,
    output logic led_lower_o,
    output logic muting_active_o,
    output logic irq_o
);
    localparam int unsigned W = lg_pkg::TMR_W;
    localparam int unsigned NS = 16;

    if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << W) || TEST_HOLD_TICKS < 1 || MUTE_LIMIT_TICKS < 1 ||
        MUTE_LIMIT_TICKS >= (1 << W) || TEST_HOLD_TICKS >= (1 << W)) begin : g_chk
        $error("light_grid_config_and_status: counts out of range");
    end

    // two-stage synchroniser for every pin
    logic [NS-1:0] pin_raw, sync1_q, sync2_q;
    assign pin_raw = {feedback_closed_i, muting_wiring_ok_i, muting_lamp_ok_i, muting_sensor_i,
                      field_clear_i, lower_beam_ok_i, upper_beam_ok_i, button_pressed_i, dip_on_i};
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end
    logic [7:0] dip;
    logic pressed, upper_s, lower_s, clear_s, msens_s, lamp_s, wiring_s, fb_s;
    assign {fb_s, wiring_s, lamp_s, msens_s, clear_s, lower_s, upper_s, pressed, dip} = sync2_q;

    // paired switch decode, function enabled when both switches are off
    logic mute_en, unlim, fb_en, ilock, cfg_ok;
    assign mute_en = !dip[lg_pkg::SW_MUTE_A] && !dip[lg_pkg::SW_MUTE_B];
    assign unlim = !dip[lg_pkg::SW_UNLIM_A] && !dip[lg_pkg::SW_UNLIM_B];
    assign fb_en = !dip[lg_pkg::SW_FB_A] && !dip[lg_pkg::SW_FB_B];
    assign ilock = !dip[lg_pkg::SW_ILOCK_A] && !dip[lg_pkg::SW_ILOCK_B];
    assign cfg_ok = dip[3:0] == dip[7:4];

    // millisecond tick
    logic [W-1:0] div_q;
    logic tick;
    assign tick = div_q == W'(TICK_CYCLES - 1);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + W'(1);
        end
    end

    // power-up mode; alignment is left only by reset
    lg_pkg::mode_e mode_q;
    logic [1:0] boot_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_q <= lg_pkg::S_BOOT;
            boot_q <= '0;
        end else begin
            unique case (mode_q)
                lg_pkg::S_BOOT: begin
                    // wait for the synchroniser to fill before the button is judged
                    if (boot_q == 2'(lg_pkg::BOOT_CYCLES - 1)) begin
                        mode_q <= pressed ? lg_pkg::S_ALIGN_HOLD : lg_pkg::S_RUN;
                    end
                    boot_q <= boot_q + 2'd1;
                end
                lg_pkg::S_ALIGN_HOLD: begin
                    if (!pressed) begin
                        mode_q <= lg_pkg::S_ALIGN;
                    end
                end
                lg_pkg::S_ALIGN: mode_q <= lg_pkg::S_ALIGN;
                lg_pkg::S_RUN: mode_q <= lg_pkg::S_RUN;
            endcase
        end
    end
    logic in_run, in_align;
    assign in_run = mode_q == lg_pkg::S_RUN;
    assign in_align = mode_q == lg_pkg::S_ALIGN || mode_q == lg_pkg::S_ALIGN_HOLD;

    // muting fault caught once, at the power-up decision
    logic mfault_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mfault_q <= 1'b0;
        end else if (mode_q == lg_pkg::S_BOOT && boot_q == 2'(lg_pkg::BOOT_CYCLES - 1)) begin
            mfault_q <= mute_en && (!lamp_s || !wiring_s || pressed);
        end
    end

    // timers for test press and muting duration
    tmr_if #(.W(W)) test_t ();
    tmr_if #(.W(W)) mute_t ();
    hold_timer #(.W(W)) u_test (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .t(test_t));
    hold_timer #(.W(W)) u_mute (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .t(mute_t));

    logic mute_req, muting, mute_expired;
    assign mute_req = in_run && mute_en && !mfault_q && msens_s;
    assign mute_expired = mute_t.done && !unlim;
    assign muting = mute_req && !mute_expired;
    assign mute_t.run = mute_req && !unlim;
    assign mute_t.tick = tick;
    assign mute_t.limit = W'(MUTE_LIMIT_TICKS);
    assign test_t.run = in_run && pressed;
    assign test_t.tick = tick;
    assign test_t.limit = W'(TEST_HOLD_TICKS);

    logic field_ok, pressed_q, rel_short, mto_q, test_q;
    assign field_ok = clear_s || muting;
    // a release counts as restart only if the press was short of a test
    assign rel_short = pressed_q && !pressed && !test_t.done;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pressed_q <= 1'b0;
            mto_q <= 1'b0;
            test_q <= 1'b0;
        end else begin
            pressed_q <= pressed;
            mto_q <= mute_expired;
            test_q <= test_t.done;
        end
    end
    logic test_trip;
    assign test_trip = test_t.done && !test_q;

    // latched trip; cleared by itself or by a short press under interlock
    logic trip_q, outs_on_q, fb_fault;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trip_q <= 1'b0;
        end else if ((in_run && !field_ok) || test_t.done) begin
            trip_q <= 1'b1;
        end else if (ilock ? rel_short : !pressed) begin
            trip_q <= 1'b0;
        end
    end

    logic [31:0] ctrl_q;
    logic may_on;
    assign may_on = in_run && cfg_ok && !mfault_q && !trip_q && field_ok &&
                    !test_t.done && !ctrl_q[lg_pkg::CTRL_FORCE_SAFE];
    // contactors must show released before the outputs are switched on
    assign fb_fault = may_on && !outs_on_q && fb_en && !fb_s;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            outs_on_q <= 1'b0;
        end else begin
            outs_on_q <= may_on && !fb_fault;
        end
    end

    // indicators from flops
    logic green_q, red_q, up_q, low_q, mute_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            green_q <= 1'b0;
            red_q <= 1'b1;
            up_q <= 1'b0;
            low_q <= 1'b0;
            mute_q <= 1'b0;
        end else if (in_align) begin
            up_q <= upper_s;
            low_q <= lower_s;
            green_q <= upper_s && lower_s && clear_s;
            red_q <= !(upper_s && lower_s && clear_s);
            mute_q <= 1'b0;
        end else begin
            up_q <= 1'b0;
            low_q <= 1'b0;
            green_q <= may_on && !fb_fault;
            red_q <= !(may_on && !fb_fault);
            mute_q <= muting;
        end
    end
    assign safety_output_pair_o = {outs_on_q, outs_on_q};
    assign led_green_o = green_q;
    assign led_red_o = red_q;
    assign led_upper_o = up_q;
    assign led_lower_o = low_q;
    assign muting_active_o = mute_q;

    // event flags, write one to clear, set wins
    logic [lg_pkg::EV_N-1:0] ev, irq_stat_q, irq_mask_q;
    logic field_ok_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            field_ok_q <= 1'b1;
        end else begin
            field_ok_q <= field_ok;
        end
    end
    assign ev = {fb_fault && outs_on_q == 1'b0, mute_expired && !mto_q, test_trip,
                 in_run && field_ok_q && !field_ok};
    logic wr_stat, wr_ctrl, wr_mask;
    assign wr_stat = wr_i && addr_i == lg_pkg::OFS_IRQ_STAT;
    assign wr_ctrl = wr_i && addr_i == lg_pkg::OFS_CTRL;
    assign wr_mask = wr_i && addr_i == lg_pkg::OFS_IRQ_MASK;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_i[lg_pkg::EV_N-1:0] : '0)) | ev;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_mask_q <= lg_pkg::IRQ_MASK_RST;
            ctrl_q <= lg_pkg::CTRL_RST;
        end else begin
            if (wr_mask) begin
                irq_mask_q <= wdata_i[lg_pkg::EV_N-1:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= {31'h0000_0000, wdata_i[lg_pkg::CTRL_FORCE_SAFE]};
            end
        end
    end
    assign irq_o = |(irq_stat_q & irq_mask_q);

    logic [31:0] status;
    always_comb begin
        status = '0;
        status[lg_pkg::ST_OUTS_ON] = outs_on_q;
        status[lg_pkg::ST_ALIGN] = in_align;
        status[lg_pkg::ST_MUTE] = mute_q;
        status[lg_pkg::ST_CFG_OK] = cfg_ok;
        status[lg_pkg::ST_MFAULT] = mfault_q;
        status[lg_pkg::ST_TRIP] = trip_q;
        status[lg_pkg::ST_DIP +: 8] = dip;
    end
    // unmapped addresses read zero
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                lg_pkg::OFS_STATUS: rdata_o <= status;
                lg_pkg::OFS_CTRL: rdata_o <= ctrl_q;
                lg_pkg::OFS_IRQ_STAT: rdata_o <= {28'h000_0000, irq_stat_q};
                lg_pkg::OFS_IRQ_MASK: rdata_o <= {28'h000_0000, irq_mask_q};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    property p_lmute; muting |-> !dip[lg_pkg::SW_MUTE_A] && !dip[lg_pkg::SW_MUTE_B]; endproperty
    a_lmute: assert property (p_lmute) else $error("muting without both switches off");
    // judged from the raw switch pair, not the decoded flag, so a decode slip shows
    property p_expire;
        (dip[lg_pkg::SW_UNLIM_A] || dip[lg_pkg::SW_UNLIM_B]) && mute_req && mute_t.done |=> !muting_active_o;
    endproperty
    a_expire: assert property (p_expire) else $error("finite muting limit not applied");
    property p_unlim; unlim && mute_req |=> mute_q; endproperty
    a_unlim: assert property (p_unlim) else $error("unlimited muting ended");
    property p_fb; $rose(outs_on_q) && $past(fb_en) |-> $past(fb_s); endproperty
    a_fb: assert property (p_fb) else $error("outputs on with contactor not released");
    property p_ilock; $fell(trip_q) && $past(ilock) |-> $past(rel_short); endproperty
    a_ilock: assert property (p_ilock) else $error("interlock cleared without release");
    property p_mfault; mfault_q |-> !outs_on_q && safety_output_pair_o == 2'b00; endproperty
    a_mfault: assert property (p_mfault) else $error("outputs on after muting fault");
    property p_align; mode_q == lg_pkg::S_ALIGN |-> ##1 mode_q == lg_pkg::S_ALIGN && !outs_on_q; endproperty
    a_align: assert property (p_align) else $error("alignment mode left or outputs on");
    property p_upper; in_align && $past(in_align) |-> led_upper_o == $past(upper_s); endproperty
    a_upper: assert property (p_upper) else $error("upper indicator wrong");
    property p_lower; in_align && $past(in_align) |-> led_lower_o == $past(lower_s); endproperty
    a_lower: assert property (p_lower) else $error("lower indicator wrong");
    property p_green; in_align && upper_s && lower_s && clear_s |=> led_green_o && !led_red_o; endproperty
    a_green: assert property (p_green) else $error("green not lit when aligned");
    property p_red; in_align && !clear_s |=> led_red_o && !led_green_o; endproperty
    a_red: assert property (p_red) else $error("red not lit on obstruction");
    property p_break; in_run && !clear_s && !muting |=> !outs_on_q && led_red_o && !led_green_o; endproperty
    a_break: assert property (p_break) else $error("beam break did not trip");
    // the outputs register the trip one edge after the timer flag rises
    property p_test; test_trip |=> !outs_on_q && led_red_o ##1 !outs_on_q; endproperty
    a_test: assert property (p_test) else $error("test press did not trip");
    property p_cfg; !cfg_ok |=> !outs_on_q; endproperty
    a_cfg: assert property (p_cfg) else $error("outputs on with invalid switches");
    c_align: cover property (mode_q == lg_pkg::S_ALIGN_HOLD ##1 mode_q == lg_pkg::S_ALIGN);
    c_on: cover property ($rose(outs_on_q));
    c_test: cover property (test_trip);
    c_mto: cover property ($rose(mute_expired));
endmodule
`default_nettype wire

// ===== test/lg_relay_model.sv
// downstream relay model whose normally closed contact reports release
`timescale 1ns/1ps
`default_nettype none
module lg_relay_model #(
    parameter int unsigned DROP_CYCLES = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [1:0] drive_i,
    input wire logic weld_i,
    output logic feedback_closed_o
);
    logic [3:0] drop_q;
    // armature needs time to drop out, so release is reported late
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drop_q <= 4'h0;
        end else if (drive_i != 2'b00) begin
            drop_q <= 4'(DROP_CYCLES);
        end else if (drop_q != 4'h0) begin
            drop_q <= drop_q - 4'h1;
        end
    end
    // welded contact never reports release
    assign feedback_closed_o = !weld_i && drive_i == 2'b00 && drop_q == 4'h0;
endmodule
`default_nettype wire

// ===== test/tb_light_grid_config_and_status.sv
// self-checking bench for the light grid configuration and status block
`timescale 1ns/1ps
`default_nettype none
module tb_light_grid_config_and_status;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] dip = 8'hFF;
    logic button = 1'b0;
    logic upper = 1'b1;
    logic lower = 1'b1;
    logic clear = 1'b1;
    logic sensor = 1'b0;
    logic lamp = 1'b1;
    logic wiring = 1'b1;
    logic weld = 1'b0;
    logic feedback;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [1:0] pair;
    logic green, red, up_led, low_led, mute_led, irq;
    logic [31:0] rv;
    int mismatches = 0;
    int n_tests = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    // short counts keep the run brief
    light_grid_config_and_status #(.TICK_CYCLES(2), .TEST_HOLD_TICKS(5), .MUTE_LIMIT_TICKS(20)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .dip_on_i(dip), .button_pressed_i(button),
        .upper_beam_ok_i(upper), .lower_beam_ok_i(lower), .field_clear_i(clear),
        .muting_sensor_i(sensor), .muting_lamp_ok_i(lamp), .muting_wiring_ok_i(wiring),
        .feedback_closed_i(feedback), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .safety_output_pair_o(pair), .led_green_o(green), .led_red_o(red),
        .led_upper_o(up_led), .led_lower_o(low_led), .muting_active_o(mute_led), .irq_o(irq));
    lg_relay_model relay_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .drive_i(pair), .weld_i(weld),
        .feedback_closed_o(feedback));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // e is {outputs, green, red}
    task automatic chk_state(input logic [3:0] e, input string msg);
        chk_word({28'h0, pair, green, red}, {28'h0, e}, msg);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // bounded wait, a hang ends the run
    task automatic wait_outs(input logic [1:0] e, input int lim, input string msg);
        int i;
        i = 0;
        #1;
        while (pair !== e && i < lim) begin
            cyc(1);
            i++;
        end
        chk_word({30'h0, pair}, {30'h0, e}, msg);
        if (pair !== e) summarize();
    endtask
    task automatic power_up(input logic [7:0] d, input logic b);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        dip <= d;
        button <= b;
        cyc(2);
        chk_state(4'h1, "reset state");
        @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        cyc(6);
    endtask
    task automatic set_field(input logic c, input logic s);
        @(posedge clk_sys_i);
        clear <= c;
        sensor <= s;
    endtask
    task automatic press(input int n);
        @(posedge clk_sys_i);
        button <= 1'b1;
        cyc(n);
        button <= 1'b0;
    endtask
    initial begin
        power_up(8'hFF, 1'b0);
        reg_rd(lg_pkg::OFS_CTRL, rv);
        chk_word(rv, lg_pkg::CTRL_RST, "ctrl reset");
        reg_rd(lg_pkg::OFS_IRQ_MASK, rv);
        chk_word(rv, 32'h0000_0000, "mask reset");
        reg_rd(8'hFC, rv);
        chk_word(rv, 32'h0000_0000, "unmapped read");
        wait_outs(2'b11, 20, "run on");
        chk_state(4'hE, "run leds");
        reg_rd(lg_pkg::OFS_STATUS, rv);
        chk_word(rv, 32'h0000_FF09, "status run");
        reg_wr(lg_pkg::OFS_CTRL, 32'h0000_0001);
        wait_outs(2'b00, 10, "force safe");
        reg_wr(lg_pkg::OFS_CTRL, 32'h0000_0000);
        wait_outs(2'b11, 20, "force released");
        reg_wr(lg_pkg::OFS_IRQ_MASK, 32'h0000_000F);
        set_field(1'b0, 1'b1);
        wait_outs(2'b00, 10, "break off");
        chk_state(4'h1, "break leds");
        chk_bit(mute_led, 1'b0, "muting while off");
        chk_bit(irq, 1'b1, "break irq");
        set_field(1'b1, 1'b0);
        wait_outs(2'b11, 20, "auto restart");
        reg_wr(lg_pkg::OFS_IRQ_STAT, 32'h0000_000F);
        cyc(2);
        chk_bit(irq, 1'b0, "irq cleared");
        press(4);
        cyc(10);
        chk_word({30'h0, pair}, 32'h0000_0003, "short press");
        @(posedge clk_sys_i);
        button <= 1'b1;
        wait_outs(2'b00, 30, "test trip");
        chk_bit(red, 1'b1, "test red");
        reg_rd(lg_pkg::OFS_IRQ_STAT, rv);
        chk_bit(rv[lg_pkg::EV_TEST], 1'b1, "test event");
        reg_wr(lg_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        cyc(1);
        chk_bit(irq, 1'b0, "masked irq");
        reg_wr(lg_pkg::OFS_IRQ_MASK, 32'h0000_000F);
        cyc(1);
        chk_bit(irq, 1'b1, "unmasked irq");
        @(posedge clk_sys_i);
        button <= 1'b0;
        wait_outs(2'b11, 20, "restart after test");
        for (int p = 0; p < 4; p++) begin
            power_up(8'hFF ^ (8'h01 << p), 1'b0);
            cyc(10);
            chk_word({30'h0, pair}, 32'h0000_0000, "pair disagree");
        end
        power_up(8'h77, 1'b0);
        press(4);
        wait_outs(2'b11, 20, "interlock start");
        set_field(1'b0, 1'b0);
        wait_outs(2'b00, 10, "interlock trip");
        set_field(1'b1, 1'b0);
        cyc(12);
        chk_word({30'h0, pair}, 32'h0000_0000, "interlock holds");
        press(4);
        wait_outs(2'b11, 20, "interlock release");
        power_up(8'hBB, 1'b0);
        wait_outs(2'b11, 20, "feedback start");
        weld <= 1'b1;
        set_field(1'b0, 1'b0);
        wait_outs(2'b00, 10, "feedback trip");
        set_field(1'b1, 1'b0);
        cyc(12);
        chk_word({30'h0, pair}, 32'h0000_0000, "welded blocks");
        reg_rd(lg_pkg::OFS_IRQ_STAT, rv);
        chk_bit(rv[lg_pkg::EV_FB], 1'b1, "feedback event");
        weld <= 1'b0;
        wait_outs(2'b11, 20, "feedback ok");
        power_up(8'hDD, 1'b0);
        wait_outs(2'b11, 20, "mute start");
        set_field(1'b1, 1'b1);
        cyc(3);
        set_field(1'b0, 1'b1);
        cyc(8);
        chk_word({30'h0, pair}, 32'h0000_0003, "muted on");
        chk_bit(mute_led, 1'b1, "muting shown");
        wait_outs(2'b00, 80, "mute timeout");
        reg_rd(lg_pkg::OFS_IRQ_STAT, rv);
        chk_bit(rv[lg_pkg::EV_MTO], 1'b1, "timeout event");
        set_field(1'b1, 1'b0);
        power_up(8'hCC, 1'b0);
        wait_outs(2'b11, 20, "unlimited start");
        set_field(1'b1, 1'b1);
        cyc(3);
        set_field(1'b0, 1'b1);
        cyc(100);
        chk_word({30'h0, pair}, 32'h0000_0003, "unlimited holds");
        set_field(1'b0, 1'b0);
        wait_outs(2'b00, 10, "sensor end");
        set_field(1'b1, 1'b0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_i);
            lamp <= (k == 1);
            wiring <= (k == 0);
            power_up(8'hDD, 1'b0);
            cyc(20);
            chk_word({30'h0, pair}, 32'h0000_0000, "muting fault");
            reg_rd(lg_pkg::OFS_STATUS, rv);
            chk_bit(rv[lg_pkg::ST_MFAULT], 1'b1, "fault flag");
        end
        lamp <= 1'b1;
        wiring <= 1'b1;
        power_up(8'hFF, 1'b1);
        button <= 1'b0;
        cyc(6);
        reg_rd(lg_pkg::OFS_STATUS, rv);
        chk_bit(rv[lg_pkg::ST_ALIGN], 1'b1, "align entered");
        upper <= 1'b1;
        lower <= 1'b0;
        clear <= 1'b0;
        cyc(5);
        chk_word({30'h0, up_led, low_led}, 32'h0000_0002, "upper only");
        chk_state(4'h1, "misaligned");
        upper <= 1'b0;
        lower <= 1'b1;
        cyc(5);
        chk_word({30'h0, up_led, low_led}, 32'h0000_0001, "lower only");
        upper <= 1'b1;
        clear <= 1'b1;
        cyc(5);
        chk_state(4'h2, "aligned");
        power_up(8'hFF, 1'b0);
        wait_outs(2'b11, 20, "after power cycle");
        summarize();
    end
endmodule
`default_nettype wire
